// ===== rtl/video_clock_output_control.sv
// Purpose: video sample clock output divider, drive and rate select, serial pin routing
// Assumes: fund_tick marks each fundamental half period, on aclk
// Notes: divider change takes effect at a falling output edge, or at once while the standard select pins read zero
//
// Design decisions made here: the AXI4-Lite register port and the address map.
`timescale 1ns/10ps
module video_clock_output_control #(
    parameter int STD_W = 6
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // fundamental clock timing
    input wire logic fund_tick,
    // axi4-lite write address
    input wire logic [vclk_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [vclk_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [vclk_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [vclk_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // device pins
    input wire logic [STD_W-1:0] video_standard_select,
    input wire logic test_host_select,
    input wire logic serial_test_clock,
    input wire logic serial_test_data_in,
    input wire logic serial_select,
    output logic serial_test_data_out,
    output logic video_clk_out_a,
    output logic drive_strength_high,
    // synthesis loop side
    output logic [vclk_pkg::DATA_W-1:0] fund_rate,
    output logic fund_rate_custom,
    // serial port users
    input wire logic host_data_out,
    input wire logic test_data_out,
    output logic host_clk_rise,
    output logic test_clk_rise,
    output logic serial_data_in_s,
    output logic serial_select_s,
    output logic test_mode
);
    // elaboration-time refusal of select widths the status word cannot hold
    generate
        if (STD_W < 1 || STD_W > 8) begin : g_bad_std
            $error("STD_W out of range");
        end
    endgenerate

    // pin synchronisers
    logic [STD_W-1:0] std_m_r, std_s_r;
    logic mode_m_r, mode_s_r, sclk_m_r, sclk_s_r, sclk_d_r;
    logic sdin_m_r, sdin_s_r, ssel_m_r, ssel_s_r;
    always_ff @(posedge aclk) begin
        std_m_r <= video_standard_select;
        std_s_r <= std_m_r;
        mode_m_r <= test_host_select;
        mode_s_r <= mode_m_r;
        sclk_m_r <= serial_test_clock;
        sclk_s_r <= sclk_m_r;
        sclk_d_r <= sclk_s_r;
        sdin_m_r <= serial_test_data_in;
        sdin_s_r <= sdin_m_r;
        ssel_m_r <= serial_select;
        ssel_s_r <= ssel_m_r;
    end

    // serial pin routing
    wire sclk_rise = sclk_s_r & ~sclk_d_r;
    wire sdout_nxt = mode_s_r ? test_data_out : host_data_out;
    logic host_rise_r, test_rise_r, sdout_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            host_rise_r <= 1'b0;
            test_rise_r <= 1'b0;
            sdout_r <= 1'b0;
        end else begin
            host_rise_r <= sclk_rise & ~mode_s_r;
            test_rise_r <= sclk_rise & mode_s_r;
            sdout_r <= sdout_nxt;
        end
    end
    assign host_clk_rise = host_rise_r;
    assign test_clk_rise = test_rise_r;
    assign serial_test_data_out = sdout_r;
    assign serial_data_in_s = sdin_s_r;
    assign serial_select_s = ssel_s_r;
    assign test_mode = mode_s_r;

    // register file
    logic [1:0] div_r;
    logic drive_r, ovr_r;
    logic [vclk_pkg::DATA_W-1:0] rate_r;
    logic aw_held_r, w_held_r, bvalid_r, rvalid_r;
    logic [vclk_pkg::ADDR_W-1:0] awaddr_r;
    logic [vclk_pkg::DATA_W-1:0] wdata_r, rdata_r;
    logic [3:0] wstrb_r;
    logic [1:0] bresp_r, rresp_r;

    assign s_axi_awready = ~aw_held_r & ~bvalid_r;
    assign s_axi_wready = ~w_held_r & ~bvalid_r;
    assign s_axi_arready = ~rvalid_r;
    wire aw_take = s_axi_awvalid & s_axi_awready;
    wire w_take = s_axi_wvalid & s_axi_wready;
    wire ar_take = s_axi_arvalid & s_axi_arready;
    wire wr_en = aw_held_r & w_held_r & ~bvalid_r;
    wire wr_ctrl = wr_en & (awaddr_r[vclk_pkg::ADDR_W-1:2] == vclk_pkg::CTRL_OFS[3:2]);
    wire wr_rate = wr_en & (awaddr_r[vclk_pkg::ADDR_W-1:2] == vclk_pkg::RATE_OFS[3:2]);
    wire wr_stat = wr_en & (awaddr_r[vclk_pkg::ADDR_W-1:2] == vclk_pkg::STAT_OFS[3:2]);
    wire wr_hit = wr_ctrl | wr_rate | wr_stat;

    logic [vclk_pkg::DATA_W-1:0] rate_wr;
    genvar gb;
    generate
        for (gb = 0; gb < 4; gb++) begin : g_lane
            assign rate_wr[gb*8 +: 8] = wstrb_r[gb] ? wdata_r[gb*8 +: 8] : rate_r[gb*8 +: 8];
        end
    endgenerate

    // clock generator state, declared here for status
    logic [1:0] half_r, cnt_r;
    logic out_r;
    wire std_zero = (std_s_r == '0);

    logic [vclk_pkg::DATA_W-1:0] ctrl_word, stat_word;
    always_comb begin
        ctrl_word = '0;
        ctrl_word[vclk_pkg::CTRL_DIV_LSB +: 2] = div_r;
        ctrl_word[vclk_pkg::CTRL_DRIVE_BIT] = drive_r;
        ctrl_word[vclk_pkg::CTRL_OVR_BIT] = ovr_r;
        stat_word = '0;
        stat_word[vclk_pkg::STAT_STD_LSB +: STD_W] = std_s_r;
        stat_word[vclk_pkg::STAT_OUT_BIT] = out_r;
        stat_word[vclk_pkg::STAT_DIV_LSB +: 2] = half_r;
        stat_word[vclk_pkg::STAT_TEST_BIT] = mode_s_r;
    end
    wire [1:0] ra = s_axi_araddr[vclk_pkg::ADDR_W-1:2];
    wire rd_ctrl = (ra == vclk_pkg::CTRL_OFS[3:2]);
    wire rd_rate = (ra == vclk_pkg::RATE_OFS[3:2]);
    wire rd_stat = (ra == vclk_pkg::STAT_OFS[3:2]);
    wire [vclk_pkg::DATA_W-1:0] rd_mux = rd_ctrl ? ctrl_word :
                                        rd_rate ? rate_r : rd_stat ? stat_word : '0;
    wire [1:0] rd_resp = (rd_ctrl | rd_rate | rd_stat) ? vclk_pkg::RESP_OKAY
                                                       : vclk_pkg::RESP_SLVERR;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            bvalid_r <= 1'b0;
            rvalid_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= '0;
            wstrb_r <= '0;
            bresp_r <= vclk_pkg::RESP_OKAY;
            rresp_r <= vclk_pkg::RESP_OKAY;
            rdata_r <= '0;
        end else begin
            if (aw_take) begin
                aw_held_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (w_take) begin
                w_held_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (wr_en) begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= wr_hit ? vclk_pkg::RESP_OKAY : vclk_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
            if (ar_take) begin
                rvalid_r <= 1'b1;
                rdata_r <= rd_mux;
                rresp_r <= rd_resp;
            end else if (s_axi_rready) begin
                rvalid_r <= 1'b0;
            end
        end
    end
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    // settings, defaults on reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_r <= vclk_pkg::DIV_RST;
            drive_r <= vclk_pkg::DRIVE_RST;
            ovr_r <= vclk_pkg::OVR_RST;
            rate_r <= vclk_pkg::RATE_RST;
        end else begin
            if (wr_ctrl && wstrb_r[0]) begin
                div_r <= wdata_r[vclk_pkg::CTRL_DIV_LSB +: 2];
                drive_r <= wdata_r[vclk_pkg::CTRL_DRIVE_BIT];
            end
            if (wr_ctrl && wstrb_r[1]) begin
                ovr_r <= wdata_r[vclk_pkg::CTRL_OVR_BIT];
            end
            if (wr_rate) begin
                rate_r <= rate_wr;
            end
        end
    end
    assign drive_strength_high = drive_r;

    // fundamental rate request to the synthesis loop
    logic [vclk_pkg::DATA_W-1:0] frate_r;
    logic fcustom_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            frate_r <= '0;
            fcustom_r <= 1'b0;
        end else begin
            frate_r <= ovr_r ? rate_r : vclk_pkg::DATA_W'(std_s_r);
            fcustom_r <= ovr_r;
        end
    end
    assign fund_rate = frate_r;
    assign fund_rate_custom = fcustom_r;

    // output clock divider
    wire [1:0] half_sel = (div_r == vclk_pkg::DIV_BY1) ? vclk_pkg::HALF_BY1 :
                          (div_r == vclk_pkg::DIV_BY2) ? vclk_pkg::HALF_BY2 : vclk_pkg::HALF_BY4;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            out_r <= 1'b0;
            cnt_r <= '0;
            half_r <= vclk_pkg::HALF_BY1;
        end else if (std_zero) begin
            out_r <= 1'b0;
            cnt_r <= '0;
            half_r <= half_sel;
        end else if (fund_tick) begin
            if (cnt_r == half_r) begin
                cnt_r <= '0;
                out_r <= ~out_r;
                if (out_r) begin
                    half_r <= half_sel;
                end
            end else begin
                cnt_r <= cnt_r + 2'h1;
            end
        end
    end
    assign video_clk_out_a = out_r;

    std_zero_low_a: assert property (@(posedge aclk) disable iff (!aresetn)
        std_zero |=> !video_clk_out_a) else $error("output not low on zero select");
    reset_dflt_a: assert property (@(posedge aclk)
        !aresetn |=> !video_clk_out_a && !drive_strength_high && !fund_rate_custom)
        else $error("reset defaults wrong");
    drive_cause_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $changed(drive_strength_high) |-> $past(wr_ctrl)) else $error("drive changed unasked");
    div1_toggle_a: assert property (@(posedge aclk) disable iff (!aresetn)
        fund_tick && !std_zero && half_r == vclk_pkg::HALF_BY1 |=> $changed(video_clk_out_a))
        else $error("divide by one missed toggle");
    toggle_cause_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $changed(video_clk_out_a) |-> $past(fund_tick) || $past(std_zero))
        else $error("toggle without tick");
    rate_std_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !ovr_r |=> fund_rate == vclk_pkg::DATA_W'($past(std_s_r)))
        else $error("rate not from select pins");
    rate_ovr_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ovr_r |=> fund_rate == $past(rate_r) && fund_rate_custom)
        else $error("custom rate not applied");
    tdo_route_a: assert property (@(posedge aclk) disable iff (!aresetn)
        mode_s_r |=> serial_test_data_out == $past(test_data_out))
        else $error("test data out not routed");
    clk_route_a: assert property (@(posedge aclk) disable iff (!aresetn)
        host_clk_rise |-> $past(!mode_s_r) && !test_clk_rise)
        else $error("host clock in test mode");
    sclk_edge_a: assert property (@(posedge aclk) disable iff (!aresetn)
        host_clk_rise || test_clk_rise |-> $past(sclk_s_r) && !$past(sclk_s_r, 2))
        else $error("serial edge without clock rise");
endmodule // video_clock_output_control

// ===== rtl/vclk_pkg.sv
// Purpose: shared constants for the video clock output control block
// Assumes: AXI4-Lite register access, 32-bit data, byte addresses
// Notes: divider codes select half-period lengths counted in fundamental ticks
package vclk_pkg;
    localparam int CLK_HZ = 25_000_000;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 4;

    // register byte offsets
    localparam logic [ADDR_W-1:0] CTRL_OFS = 4'h0;
    localparam logic [ADDR_W-1:0] RATE_OFS = 4'h4;
    localparam logic [ADDR_W-1:0] STAT_OFS = 4'h8;

    // control field positions
    localparam int CTRL_DIV_LSB = 0;
    localparam int CTRL_DRIVE_BIT = 4;
    localparam int CTRL_OVR_BIT = 8;

    // status field positions
    localparam int STAT_STD_LSB = 0;
    localparam int STAT_OUT_BIT = 8;
    localparam int STAT_DIV_LSB = 9;
    localparam int STAT_TEST_BIT = 12;

    // divider select codes
    localparam logic [1:0] DIV_BY1 = 2'h0;
    localparam logic [1:0] DIV_BY2 = 2'h1;
    localparam logic [1:0] DIV_BY4 = 2'h2;

    // half period minus one, in fundamental ticks
    localparam logic [1:0] HALF_BY1 = 2'h0;
    localparam logic [1:0] HALF_BY2 = 2'h1;
    localparam logic [1:0] HALF_BY4 = 2'h3;

    // reset values
    localparam logic [1:0] DIV_RST = DIV_BY1;
    localparam logic DRIVE_RST = 1'b0;
    localparam logic OVR_RST = 1'b0;
    localparam logic [DATA_W-1:0] RATE_RST = 32'h0000_0000;

    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== test/app_side_model.sv
// Purpose: application-side logic beside the video clock output
// Assumes: same aclk domain as the block
// Notes: host and test data follow different patterns so routing shows
`timescale 1ns/10ps
module app_side_model (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // data toward the serial output pin
    output logic host_data_out,
    output logic test_data_out
);
    logic [1:0] pat_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) pat_r <= 2'h0;
        else pat_r <= pat_r + 2'h1;
    end
    assign host_data_out = pat_r[0];
    assign test_data_out = pat_r[1];
endmodule // app_side_model

// ===== test/video_clock_output_control_tb_top.sv
// Purpose: self-checking bench for the video clock output control
// Assumes: 25 MHz aclk, axi4-lite master tasks, fund_tick pulses from bench
// Notes: expected values come from the bench's own register model
`timescale 1ns/10ps
module video_clock_output_control_tb_top;
    logic aclk = 1'b0, aresetn = 1'b0, fund_tick = 1'b0;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, fund_rate;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [5:0] video_standard_select = 6'h05;
    logic test_host_select = 1'b0, serial_test_clock = 1'b0;
    logic serial_test_data_in = 1'b0, serial_select = 1'b0;
    logic serial_test_data_out, video_clk_out_a, drive_strength_high, fund_rate_custom;
    logic host_data_out, test_data_out, host_clk_rise, test_clk_rise;
    logic serial_data_in_s, serial_select_s, test_mode, exp_b, hi_seen;
    logic [3:0] hc, tc;
    logic [31:0] d, rate, val;
    int error_cnt = 0, cmp_count = 0, hi, lo, half;

    always #20 aclk = ~aclk;

    video_clock_output_control u_dut (.aclk(aclk), .aresetn(aresetn), .fund_tick(fund_tick),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .video_standard_select(video_standard_select),
        .test_host_select(test_host_select), .serial_test_clock(serial_test_clock),
        .serial_test_data_in(serial_test_data_in), .serial_select(serial_select),
        .serial_test_data_out(serial_test_data_out), .video_clk_out_a(video_clk_out_a),
        .drive_strength_high(drive_strength_high), .fund_rate(fund_rate),
        .fund_rate_custom(fund_rate_custom), .host_data_out(host_data_out),
        .test_data_out(test_data_out), .host_clk_rise(host_clk_rise),
        .test_clk_rise(test_clk_rise), .serial_data_in_s(serial_data_in_s),
        .serial_select_s(serial_select_s), .test_mode(test_mode));
    app_side_model u_app (.aclk(aclk), .aresetn(aresetn), .host_data_out(host_data_out),
        .test_data_out(test_data_out));

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    // handshakes are judged on the rising edge itself, before the design updates
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] dv, output logic [1:0] rs);
        logic aw_pend, w_pend;
        aw_pend = 1'b1;
        w_pend = 1'b1;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= dv;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (aw_pend || w_pend) begin
            @(posedge aclk);
            if (aw_pend && s_axi_awready === 1'b1) begin
                aw_pend = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (w_pend && s_axi_wready === 1'b1) begin
                w_pend = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [3:0] a, output logic [31:0] dv, output logic [1:0] rs);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        dv = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic tick();
        @(posedge aclk) fund_tick <= 1'b1;
        @(posedge aclk) fund_tick <= 1'b0;
        repeat ($urandom_range(0, 2)) @(posedge aclk);
        #1;
    endtask
    // ticks in the high and the low phase of one full output period
    task automatic measure(output int h, output int l);
        h = 0;
        l = 0;
        while (video_clk_out_a !== 1'b0) tick();
        while (video_clk_out_a !== 1'b1) tick();
        while (video_clk_out_a === 1'b1) begin tick(); h++; end
        while (video_clk_out_a === 1'b0) begin tick(); l++; end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    initial begin
        #(40 * 20000);
        error_cnt++;
        tally_and_finish();
    end

    initial begin
        void'($urandom(32'hBE33));
        repeat (2) @(posedge aclk);
        video_standard_select <= 6'($urandom_range(1, 63));
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
        #1;
        check("drive", drive_strength_high, 0);
        check("rate", fund_rate, 32'(video_standard_select));
        axi_rd(vclk_pkg::CTRL_OFS, d, r);
        check("ctrl", d & 32'h113, 0);
        rate = $urandom;
        axi_wr(vclk_pkg::RATE_OFS, rate, r);
        axi_wr(vclk_pkg::CTRL_OFS, 32'h100, r);
        #1;
        check("rate_ovr", fund_rate, rate);
        check("custom", fund_rate_custom, 1);
        axi_rd(vclk_pkg::RATE_OFS, d, r);
        check("rate_rd", d, rate);
        s_axi_wstrb <= 4'h1;
        axi_wr(vclk_pkg::RATE_OFS, ~rate, r);
        s_axi_wstrb <= 4'hF;
        rate = {rate[31:8], ~rate[7:0]};
        axi_rd(vclk_pkg::RATE_OFS, d, r);
        check("rate_strb", d, rate);
        check("rate_live", fund_rate, rate);
        for (int dv = 0; dv < 4; dv++) begin
            val = 32'(dv) | (32'($urandom_range(0, 1)) << 4) | 32'h100;
            axi_wr(vclk_pkg::CTRL_OFS, val, r);
            check("wr_resp", r, vclk_pkg::RESP_OKAY);
            #1;
            check("drive", drive_strength_high, val[4]);
            measure(hi, lo);
            measure(hi, lo);
            half = (dv == 0) ? 1 : (dv == 1) ? 2 : 4;
            check("high_ticks", hi, half);
            check("low_ticks", lo, half);
        end
        axi_wr(4'hC, 32'h0, r);
        check("bad_wr", r, vclk_pkg::RESP_SLVERR);
        axi_rd(4'hC, d, r);
        check("bad_rd", r, vclk_pkg::RESP_SLVERR);
        axi_rd(vclk_pkg::CTRL_OFS, d, r);
        check("ctrl_keep", d & 32'h113, val & 32'h113);
        video_standard_select <= 6'h00;
        repeat (3) @(posedge aclk);
        #1;
        hi_seen = 1'b0;
        repeat (10) begin tick(); hi_seen = hi_seen | video_clk_out_a; end
        check("zero_sel", hi_seen, 0);
        axi_rd(vclk_pkg::STAT_OFS, d, r);
        check("status", d, 32'(vclk_pkg::HALF_BY4) << vclk_pkg::STAT_DIV_LSB);
        check("stat_resp", r, vclk_pkg::RESP_OKAY);
        video_standard_select <= 6'($urandom_range(1, 63));
        for (int m = 0; m < 2; m++) begin
            test_host_select <= 1'(m);
            serial_test_data_in <= 1'($urandom);
            serial_select <= 1'($urandom);
            repeat (4) @(posedge aclk);
            #1;
            check("mode", test_mode, m);
            check("sdin", serial_data_in_s, serial_test_data_in);
            check("ssel", serial_select_s, serial_select);
            for (int i = 0; i < 4; i++) begin
                @(negedge aclk) exp_b = m ? test_data_out : host_data_out;
                @(negedge aclk) check("sdout", serial_test_data_out, exp_b);
            end
            @(posedge aclk) serial_test_clock <= 1'b1;
            hc = 4'h0;
            tc = 4'h0;
            repeat (8) begin @(negedge aclk); hc += host_clk_rise; tc += test_clk_rise; end
            check("host_rise", hc, m ? 0 : 1);
            check("test_rise", tc, m ? 1 : 0);
            @(posedge aclk) serial_test_clock <= 1'b0;
        end
        tick();
        @(posedge aclk) aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        #1;
        check("rst_out", video_clk_out_a, 0);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
        #1;
        check("rst_custom", fund_rate_custom, 0);
        check("rst_rate", fund_rate, 32'(video_standard_select));
        check("rst_drive", drive_strength_high, 0);
        axi_rd(vclk_pkg::CTRL_OFS, d, r);
        check("rst_ctrl", d & 32'h113, 0);
        tally_and_finish();
    end
endmodule // video_clock_output_control_tb_top
